/* rtl/phy_mgmt_defs.vh */
// constants for the management, interrupt and rgmii configuration block
// included by the design files; definitions only
`ifndef PHY_MGMT_DEFS_VH
`define PHY_MGMT_DEFS_VH

// register addresses (5-bit management index)
`define ADDR_BASIC_CTRL 5'h00
`define ADDR_BASIC_STAT 5'h01
`define ADDR_AN_EXP 5'h06
`define ADDR_IDLE_CNT 5'h0a
`define ADDR_MODE_STAT 5'h11
`define ADDR_CTRL_IND 5'h1b
`define ADDR_SRC_FLAGS 5'h1d
`define ADDR_INT_MASK 5'h1e

// basic control fields
`define BC_RENEG 9
`define BC_ISOLATE 10

// delay enable fields of the control/indication register
`define CI_TX_DELAY 9
`define CI_RX_DELAY 8

// flag positions, shared by mask and flags
`define FL_TX_OVF 10
`define FL_TX_UNF 9
`define FL_IDLE_OVF 8
`define FL_ENERGY 7
`define FL_AN_DONE 6
`define FL_RFAULT 5
`define FL_LINK_DOWN 4
`define FL_PD_FAULT 2
`define FL_PAGE_RX 1
`define FLAG_IMPL 16'h07f6

`define MASK_RESET 16'h0000
// edge detector idle: energy present, link down
`define STAT_EDGE_RESET 9'h024
`define UNMAPPED_DATA 16'hffff

// energy timeout: 256 ms at a 4 ns clock
`define ENERGY_TIMEOUT_MS 256
`define CLK_PERIOD_NS 4
`define ENERGY_TIMEOUT_CYC (`ENERGY_TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)

`endif

/* rtl/mdio_slave.v */
// serial management port slave: clause 22 frames sampled on mdc rising edges
// assumes mdc and mdio_in are already synchronised into clk
`timescale 1ns/1ns
`include "phy_mgmt_defs.vh"

module mdio_slave (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // synchronised pins
  input wire mdc_s,
  input wire mdio_s,
  input wire [4:0] phy_addr,
  // management pin drive
  output reg mdio_out_ff,
  output reg mdio_oe_ff,
  // register access
  output reg wr_pulse_ff,
  output reg rd_pulse_ff,
  output reg [4:0] reg_addr_ff,
  output reg [15:0] wr_data_ff,
  input wire [15:0] rd_data
);

  localparam ST_PRE = 3'h0;
  localparam ST_HDR = 3'h1;
  localparam ST_TA = 3'h2;
  localparam ST_RD = 3'h3;
  localparam ST_WR = 3'h4;

  reg mdc_d_ff;
  reg [2:0] st_ff;
  reg [5:0] cnt_ff;
  reg [13:0] hdr_ff;
  reg [15:0] sh_ff;
  reg mine_ff;
  reg is_rd_ff;
  wire rise;
  wire fall;
  wire [13:0] hdr_n;

  assign rise = mdc_s & ~mdc_d_ff;
  assign fall = ~mdc_s & mdc_d_ff;
  assign hdr_n = {hdr_ff[12:0], mdio_s};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_d_ff <= 1'b0;
      st_ff <= ST_PRE;
      cnt_ff <= 6'h00;
      hdr_ff <= 14'h0000;
      sh_ff <= 16'h0000;
      mine_ff <= 1'b0;
      is_rd_ff <= 1'b0;
      mdio_out_ff <= 1'b1;
      mdio_oe_ff <= 1'b0;
      wr_pulse_ff <= 1'b0;
      rd_pulse_ff <= 1'b0;
      reg_addr_ff <= 5'h00;
      wr_data_ff <= 16'h0000;
    end else begin
      mdc_d_ff <= mdc_s;
      wr_pulse_ff <= 1'b0;
      rd_pulse_ff <= 1'b0;
      if (rise) begin
        case (st_ff)
          ST_PRE: begin
            // 32 ones then start 01
            if (mdio_s)
              cnt_ff <= (cnt_ff == 6'h20) ? cnt_ff : cnt_ff + 6'h01;
            else if (cnt_ff == 6'h20) begin
              st_ff <= ST_HDR;
              cnt_ff <= 6'h00;
              hdr_ff <= 14'h0000;
            end else
              cnt_ff <= 6'h00;
          end
          ST_HDR: begin
            // start bit 1, op 2, phy 5, reg 5
            hdr_ff <= hdr_n;
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == 6'h0c) begin
              is_rd_ff <= (hdr_n[11:10] == 2'b10);
              mine_ff <= hdr_n[12] && (hdr_n[9:5] == phy_addr) && (hdr_n[11] ^ hdr_n[10]);
              reg_addr_ff <= hdr_n[4:0];
              cnt_ff <= 6'h00;
              st_ff <= ST_TA;
            end
          end
          ST_TA: begin
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == 6'h01) begin
              cnt_ff <= 6'h00;
              st_ff <= is_rd_ff ? ST_RD : ST_WR;
            end
          end
          ST_RD: begin
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == 6'h0f) begin
              st_ff <= ST_PRE;
              cnt_ff <= 6'h00;
            end
          end
          default: begin
            sh_ff <= {sh_ff[14:0], mdio_s};
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == 6'h0f) begin
              wr_data_ff <= {sh_ff[14:0], mdio_s};
              wr_pulse_ff <= mine_ff;
              st_ff <= ST_PRE;
              cnt_ff <= 6'h00;
            end
          end
        endcase
      end
      // drive read data after mdc falls
      if (fall) begin
        if (st_ff == ST_TA && is_rd_ff && mine_ff && cnt_ff == 6'h01) begin
          mdio_oe_ff <= 1'b1;
          mdio_out_ff <= 1'b0;
          sh_ff <= rd_data;
          // read side effects only once the word is captured
          rd_pulse_ff <= 1'b1;
        end else if (st_ff == ST_RD && mdio_oe_ff) begin
          mdio_out_ff <= sh_ff[15];
          sh_ff <= {sh_ff[14:0], 1'b0};
        end else begin
          mdio_oe_ff <= 1'b0;
          mdio_out_ff <= 1'b1;
        end
      end
    end
  end

endmodule

/* rtl/phy_mgmt_irq_rgmii_cfg.v */
// management, interrupt and rgmii configuration of the transceiver
// assumes pins arrive asynchronous; line status comes from the media logic
// Contract
// - mac link is rxc, rxd[3:0], rxctrl out and txc, txd[3:0], txctrl in
// - device drives rxc, rxd, rxctrl; rxc times receive data
// - no-delay mode adds no internal clock delay
// - hybrid mode delays both transmit and receive clocks
// - bit 9 enables tx delay, bit 8 rx delay; 01b standard mode
// - delay bits reset from strap; high strap selects hybrid
// - isolate holds mac outputs high and ignores mac inputs
// - management port and interrupt keep working in isolate
// - isolate suspends media operations
// - unimplemented register reads return ffff
// - mdio sampled on rising mdc
// - active-low interrupt only for enabled events
// - interrupt asserts on event, deasserts on clearing condition
// - all enables cleared after reset
// - mask bits 10 and 9: buffer overflow, underflow, clear when resolved
// - flag 7 on rising energy, clears on fall or flags read
// - flag 6 on rising negotiation done, clears on fall or flags read
// - flag 5 rising fault, flag 4 link fall; status or flags read clears
// - flag 2 parallel fault; clears on fall, reads, renegotiate, link loss
// - flag 1 page received; clears on fall, reads, renegotiate, link loss
// - energy resets to one, clears after 256 ms without line energy
`timescale 1ns/1ns
`include "phy_mgmt_defs.vh"

module phy_mgmt_irq_rgmii_cfg #(
  parameter ENERGY_TIMEOUT = `ENERGY_TIMEOUT_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // straps and address
  input wire delay_mode_strap,
  input wire [4:0] phy_addr,
  // management port pins
  input wire mdc,
  input wire mdio_in,
  output reg mdio_out_ff,
  output reg mdio_oe_ff,
  // interrupt pin
  output reg irq_n_ff,
  // mac transmit side
  input wire txc,
  input wire [3:0] txd,
  input wire txctrl,
  // mac receive side from core
  input wire rxc_core,
  input wire [3:0] rxd_core,
  input wire rxctrl_core,
  // mac receive pins
  output reg rxc_ff,
  output reg [3:0] rxd_ff,
  output reg rxctrl_ff,
  // transmit toward core
  output reg [3:0] core_txd_ff,
  output reg core_txctrl_ff,
  output reg core_txc_ff,
  // delay select to pads
  output reg tx_delay_en_ff,
  output reg rx_delay_en_ff,
  // media status inputs
  input wire line_energy,
  input wire an_complete,
  input wire remote_fault,
  input wire link_up,
  input wire pd_fault,
  input wire page_rx,
  input wire tx_overflow,
  input wire tx_underflow,
  input wire idle_err_ovf,
  // media control
  output reg media_enable_ff,
  output reg renegotiate_ff
);

  reg [1:0] mdc_sy_ff;
  reg [1:0] mdio_sy_ff;
  reg [1:0] strap_sy_ff;
  reg [5:0] tx_sy_ff;
  reg [15:0] ctrl_ff;
  reg [1:0] delay_ff;
  reg strap_done_ff;
  reg [15:0] mask_ff;
  reg [15:0] flags_ff;
  reg [15:0] nxt_flags;
  reg energy_ff;
  reg [31:0] quiet_cnt_ff;
  reg [8:0] stat_d_ff;
  reg [15:0] rd_data;
  wire wr_pulse;
  wire rd_pulse;
  wire [4:0] reg_addr;
  wire [15:0] wr_data;
  wire mdio_out_w;
  wire mdio_oe_w;
  wire isolate;
  wire [8:0] stat;
  wire [8:0] rise;
  wire [8:0] fall;
  wire rd_flags;
  wire rd_basic;
  wire rd_exp;
  wire link_lost;
  wire reneg;

  assign isolate = ctrl_ff[`BC_ISOLATE];
  assign stat = {tx_overflow, tx_underflow, idle_err_ovf, energy_ff, an_complete,
                 remote_fault, ~link_up, pd_fault, page_rx};
  assign rise = stat & ~stat_d_ff;
  assign fall = ~stat & stat_d_ff;
  assign rd_flags = rd_pulse && reg_addr == `ADDR_SRC_FLAGS;
  assign rd_basic = rd_pulse && reg_addr == `ADDR_BASIC_STAT;
  assign rd_exp = rd_pulse && reg_addr == `ADDR_AN_EXP;
  assign link_lost = rise[2];
  assign reneg = renegotiate_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_sy_ff <= 2'b00;
      mdio_sy_ff <= 2'b11;
      tx_sy_ff <= 6'h00;
    end else begin
      mdc_sy_ff <= {mdc_sy_ff[0], mdc};
      mdio_sy_ff <= {mdio_sy_ff[0], mdio_in};
      tx_sy_ff <= {txc, txctrl, txd};
    end
  end

  // strap sampled while reset is held
  always @(posedge clk) begin
    strap_sy_ff <= {strap_sy_ff[0], delay_mode_strap};
  end

  mdio_slave u_mdio (
    .clk(clk),
    .rst_n(rst_n),
    .mdc_s(mdc_sy_ff[1]),
    .mdio_s(mdio_sy_ff[1]),
    .phy_addr(phy_addr),
    .mdio_out_ff(mdio_out_w),
    .mdio_oe_ff(mdio_oe_w),
    .wr_pulse_ff(wr_pulse),
    .rd_pulse_ff(rd_pulse),
    .reg_addr_ff(reg_addr),
    .wr_data_ff(wr_data),
    .rd_data(rd_data)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdio_out_ff <= 1'b1;
      mdio_oe_ff <= 1'b0;
    end else begin
      mdio_out_ff <= mdio_out_w;
      mdio_oe_ff <= mdio_oe_w;
    end
  end

  // control, mask and delay registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 16'h0000;
      mask_ff <= `MASK_RESET;
      delay_ff <= 2'b00;
      strap_done_ff <= 1'b0;
      renegotiate_ff <= 1'b0;
    end else begin
      renegotiate_ff <= 1'b0;
      if (!strap_done_ff) begin
        strap_done_ff <= 1'b1;
        delay_ff <= {strap_sy_ff[1], strap_sy_ff[1]};
      end else if (wr_pulse && reg_addr == `ADDR_CTRL_IND) begin
        delay_ff <= {wr_data[`CI_TX_DELAY], wr_data[`CI_RX_DELAY]};
      end
      if (wr_pulse && reg_addr == `ADDR_BASIC_CTRL) begin
        ctrl_ff <= wr_data & ~(16'h0001 << `BC_RENEG);
        renegotiate_ff <= wr_data[`BC_RENEG];
      end
      if (wr_pulse && reg_addr == `ADDR_INT_MASK)
        mask_ff <= wr_data & `FLAG_IMPL;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_delay_en_ff <= 1'b0;
      rx_delay_en_ff <= 1'b0;
    end else begin
      tx_delay_en_ff <= delay_ff[1];
      rx_delay_en_ff <= delay_ff[0];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      energy_ff <= 1'b1;
      quiet_cnt_ff <= 32'h00000000;
    end else if (line_energy) begin
      energy_ff <= 1'b1;
      quiet_cnt_ff <= 32'h00000000;
    end else if (quiet_cnt_ff >= ENERGY_TIMEOUT - 1) begin
      energy_ff <= 1'b0;
    end else begin
      quiet_cnt_ff <= quiet_cnt_ff + 32'h00000001;
    end
  end

  // source flag update; set wins over clear
  always @* begin
    nxt_flags = flags_ff;
    nxt_flags[`FL_TX_OVF] = tx_overflow;
    nxt_flags[`FL_TX_UNF] = tx_underflow;
    if (rd_pulse && reg_addr == `ADDR_IDLE_CNT)
      nxt_flags[`FL_IDLE_OVF] = 1'b0;
    if (rise[6])
      nxt_flags[`FL_IDLE_OVF] = 1'b1;
    if (fall[5] || rd_flags)
      nxt_flags[`FL_ENERGY] = 1'b0;
    if (rise[5])
      nxt_flags[`FL_ENERGY] = 1'b1;
    if (fall[4] || rd_flags)
      nxt_flags[`FL_AN_DONE] = 1'b0;
    if (rise[4])
      nxt_flags[`FL_AN_DONE] = 1'b1;
    if (fall[3] || rd_flags || rd_basic)
      nxt_flags[`FL_RFAULT] = 1'b0;
    if (rise[3])
      nxt_flags[`FL_RFAULT] = 1'b1;
    if (rd_flags || rd_basic)
      nxt_flags[`FL_LINK_DOWN] = 1'b0;
    if (rise[2])
      nxt_flags[`FL_LINK_DOWN] = 1'b1;
    if (fall[1] || rd_flags || rd_exp || reneg || link_lost)
      nxt_flags[`FL_PD_FAULT] = 1'b0;
    if (rise[1])
      nxt_flags[`FL_PD_FAULT] = 1'b1;
    if (fall[0] || rd_flags || rd_exp || reneg || link_lost)
      nxt_flags[`FL_PAGE_RX] = 1'b0;
    if (rise[0])
      nxt_flags[`FL_PAGE_RX] = 1'b1;
    nxt_flags = nxt_flags & `FLAG_IMPL;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= 16'h0000;
      stat_d_ff <= `STAT_EDGE_RESET;
    end else begin
      flags_ff <= nxt_flags;
      stat_d_ff <= stat;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irq_n_ff <= 1'b1;
    else
      irq_n_ff <= ~|(flags_ff & mask_ff);
  end

  always @* begin
    if (reg_addr == `ADDR_BASIC_CTRL)
      rd_data = ctrl_ff;
    else if (reg_addr == `ADDR_BASIC_STAT)
      rd_data = {10'h000, an_complete, remote_fault, 1'b0, link_up, 2'b00};
    else if (reg_addr == `ADDR_AN_EXP)
      rd_data = {11'h000, pd_fault, 2'b00, page_rx, 1'b0};
    else if (reg_addr == `ADDR_MODE_STAT)
      rd_data = {14'h0000, energy_ff, 1'b0};
    else if (reg_addr == `ADDR_CTRL_IND)
      rd_data = {6'h00, delay_ff, 8'h00};
    else if (reg_addr == `ADDR_SRC_FLAGS)
      rd_data = flags_ff;
    else if (reg_addr == `ADDR_INT_MASK)
      rd_data = mask_ff;
    else
      rd_data = `UNMAPPED_DATA;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxc_ff <= 1'b1;
      rxd_ff <= 4'hf;
      rxctrl_ff <= 1'b1;
    end else if (isolate) begin
      rxc_ff <= 1'b1;
      rxd_ff <= 4'hf;
      rxctrl_ff <= 1'b1;
    end else begin
      rxc_ff <= rxc_core;
      rxd_ff <= rxd_core;
      rxctrl_ff <= rxctrl_core;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_txd_ff <= 4'h0;
      core_txctrl_ff <= 1'b0;
      core_txc_ff <= 1'b0;
    end else if (isolate) begin
      core_txd_ff <= 4'h0;
      core_txctrl_ff <= 1'b0;
      core_txc_ff <= 1'b0;
    end else begin
      core_txd_ff <= tx_sy_ff[3:0];
      core_txctrl_ff <= tx_sy_ff[4];
      core_txc_ff <= tx_sy_ff[5];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      media_enable_ff <= 1'b0;
    else
      media_enable_ff <= ~isolate;
  end

endmodule

/* testbench/station_mgr.sv */
// station manager model: drives mdc and mdio frames, reads device data
// assumes the bench resolves the mdio wire with a pull-up
`timescale 1ns/1ns
module station_mgr #(
  parameter PHY = 5'h01
) (
  // management clock and drive
  output reg mdc,
  output reg mdio_drv,
  output reg mdio_en,
  // resolved wire
  input wire mdio_line
);
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
    mdio_en = 1'b0;
  end
  task automatic frame(input [1:0] op, input [4:0] ra, input [15:0] wd, output [15:0] rd);
    reg [63:0] bits;
    // keep pin edges off the clk sampling edge
    #1;
    bits = {32'hffffffff, 2'b01, op, PHY, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      mdio_en = !(op == 2'b10 && i < 18);
      mdio_drv = bits[i];
      #100 mdc = 1'b1;
      if (i < 16) rd[i] = mdio_line;
      #200 mdc = 1'b0;
      #100;
    end
    mdio_en = 1'b0;
  endtask
endmodule

/* testbench/phy_mgmt_chk_sva.sv */
// port checker for the management, interrupt and rgmii block
// assumes the top module's ports only; bound below
`timescale 1ns/1ns
module phy_mgmt_chk (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // pins
  input wire delay_mode_strap,
  input wire mdc,
  input wire mdio_out_ff,
  input wire mdio_oe_ff,
  input wire irq_n_ff,
  // mac sides
  input wire txc,
  input wire [3:0] txd,
  input wire txctrl,
  input wire rxc_core,
  input wire [3:0] rxd_core,
  input wire rxctrl_core,
  input wire rxc_ff,
  input wire [3:0] rxd_ff,
  input wire rxctrl_ff,
  input wire [3:0] core_txd_ff,
  input wire core_txctrl_ff,
  input wire core_txc_ff,
  // control
  input wire tx_delay_en_ff,
  input wire rx_delay_en_ff,
  input wire media_enable_ff,
  input wire renegotiate_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  iso_rx_a: assert property (!media_enable_ff |-> rxc_ff && rxctrl_ff && rxd_ff == 4'hf)
    else $error("rx pins not high while isolated");
  iso_tx_a: assert property (!media_enable_ff |-> core_txd_ff == 4'h0 && !core_txctrl_ff && !core_txc_ff)
    else $error("tx inputs passed while isolated");
  tx_pass_a: assert property (media_enable_ff && $past(media_enable_ff) |->
    core_txd_ff == $past(txd, 2) && core_txctrl_ff == $past(txctrl, 2) && core_txc_ff == $past(txc, 2))
    else $error("tx path mismatch");
  rx_pass_a: assert property (media_enable_ff && $past(media_enable_ff) |->
    rxd_ff == $past(rxd_core) && rxctrl_ff == $past(rxctrl_core) && rxc_ff == $past(rxc_core))
    else $error("rx path mismatch");
  ta_zero_a: assert property ($rose(mdio_oe_ff) |-> !mdio_out_ff)
    else $error("turnaround bit not zero");
  mdio_steady_a: assert property (mdc && $past(mdc, 8) |-> $stable(mdio_oe_ff) && $stable(mdio_out_ff))
    else $error("mdio changed while mdc high");
  strap_delay_a: assert property ($rose(rst_n) |-> ##3
    tx_delay_en_ff == delay_mode_strap && rx_delay_en_ff == delay_mode_strap)
    else $error("delay bits not from strap");
  irq_masked_a: assert property ($rose(rst_n) |-> irq_n_ff [*8])
    else $error("interrupt after reset");
  reneg_pulse_a: assert property (renegotiate_ff |=> !renegotiate_ff)
    else $error("renegotiate pulse too long");
endmodule
bind phy_mgmt_irq_rgmii_cfg phy_mgmt_chk u_chk (.clk(clk), .rst_n(rst_n), .delay_mode_strap(delay_mode_strap),
  .mdc(mdc), .mdio_out_ff(mdio_out_ff), .mdio_oe_ff(mdio_oe_ff), .irq_n_ff(irq_n_ff), .txc(txc), .txd(txd),
  .txctrl(txctrl), .rxc_core(rxc_core), .rxd_core(rxd_core), .rxctrl_core(rxctrl_core), .rxc_ff(rxc_ff),
  .rxd_ff(rxd_ff), .rxctrl_ff(rxctrl_ff), .core_txd_ff(core_txd_ff), .core_txctrl_ff(core_txctrl_ff),
  .core_txc_ff(core_txc_ff), .tx_delay_en_ff(tx_delay_en_ff), .rx_delay_en_ff(rx_delay_en_ff),
  .media_enable_ff(media_enable_ff), .renegotiate_ff(renegotiate_ff));

/* testbench/test_phy_mgmt_irq_rgmii_cfg.sv */
// self-checking bench for the management, interrupt and rgmii block
// assumes the station manager model and the bound checker
`timescale 1ns/1ns
`include "phy_mgmt_defs.vh"
module test_phy_mgmt_irq_rgmii_cfg;
  reg clk = 1'b0, rst_n = 1'b0, an_complete = 1'b0, link_up = 1'b1, pd_fault = 1'b0;
  reg page_rx = 1'b0, remote_fault = 1'b0, tx_overflow = 1'b0;
  reg line_energy = 1'b1, tx_underflow = 1'b0, idle_err_ovf = 1'b0, delay_mode_strap = 1'b1;
  reg txc = 1'b0, txctrl = 1'b0, rxc_core = 1'b0, rxctrl_core = 1'b0;
  reg [3:0] txd = 4'h0, rxd_core = 4'h0;
  reg [7:0] cnt = 8'h00;
  wire mdc, mdio_drv, mdio_en, mdio_out_ff, mdio_oe_ff, irq_n_ff, rxc_ff, rxctrl_ff, core_txctrl_ff, core_txc_ff;
  wire tx_delay_en_ff, rx_delay_en_ff, media_enable_ff, renegotiate_ff;
  wire [3:0] rxd_ff, core_txd_ff;
  wire mdio_line = mdio_oe_ff ? mdio_out_ff : (mdio_en ? mdio_drv : 1'b1);
  int err_total = 0, compares = 0;
  reg [15:0] rv;
  always #2 clk = ~clk;
  // mac link clock of 64 ns, moving data both sides
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
    {txc, rxc_core} <= {2{cnt[3]}};
    txd <= cnt[7:4];
    txctrl <= cnt[2];
    rxd_core <= cnt[6:3];
    rxctrl_core <= cnt[4];
  end
  station_mgr #(.PHY(5'h01)) u_mgr (.mdc(mdc), .mdio_drv(mdio_drv), .mdio_en(mdio_en), .mdio_line(mdio_line));
  phy_mgmt_irq_rgmii_cfg #(.ENERGY_TIMEOUT(100)) DUT (.clk(clk), .rst_n(rst_n), .delay_mode_strap(delay_mode_strap),
    .phy_addr(5'h01), .mdc(mdc), .mdio_in(mdio_line), .mdio_out_ff(mdio_out_ff), .mdio_oe_ff(mdio_oe_ff),
    .irq_n_ff(irq_n_ff), .txc(txc), .txd(txd), .txctrl(txctrl), .rxc_core(rxc_core), .rxd_core(rxd_core),
    .rxctrl_core(rxctrl_core), .rxc_ff(rxc_ff), .rxd_ff(rxd_ff), .rxctrl_ff(rxctrl_ff), .core_txd_ff(core_txd_ff),
    .core_txctrl_ff(core_txctrl_ff), .core_txc_ff(core_txc_ff), .tx_delay_en_ff(tx_delay_en_ff),
    .rx_delay_en_ff(rx_delay_en_ff), .line_energy(line_energy), .an_complete(an_complete),
    .remote_fault(remote_fault), .link_up(link_up), .pd_fault(pd_fault), .page_rx(page_rx),
    .tx_overflow(tx_overflow), .tx_underflow(tx_underflow), .idle_err_ovf(idle_err_ovf),
    .media_enable_ff(media_enable_ff), .renegotiate_ff(renegotiate_ff));
  task automatic chk(input [15:0] got, input [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input [4:0] ra);
    u_mgr.frame(2'b10, ra, 16'h0000, rv);
    wt(8);
  endtask
  task automatic wr(input [4:0] ra, input [15:0] wd);
    reg [15:0] dummy;
    u_mgr.frame(2'b01, ra, wd, dummy);
    wt(8);
  endtask
  task automatic t_reset;
    chk({15'h0, irq_n_ff}, 16'h0001);
    chk({14'h0, tx_delay_en_ff, rx_delay_en_ff}, 16'h0003);
    rd(`ADDR_INT_MASK);
    chk(rv, `MASK_RESET);
  endtask
  task automatic t_unmapped;
    rd(`ADDR_IDLE_CNT);
    chk(rv, 16'hffff);
    chk({15'h0, irq_n_ff}, 16'h0001);
    rd(5'h0e);
    chk(rv, 16'hffff);
  endtask
  task automatic t_delay;
    wr(`ADDR_CTRL_IND, 16'h0100);
    chk({14'h0, tx_delay_en_ff, rx_delay_en_ff}, 16'h0001);
  endtask
  task automatic t_irq;
    wr(`ADDR_INT_MASK, 16'h0040);
    pd_fault <= 1'b1;
    tx_overflow <= 1'b1;
    wt(10);
    chk({15'h0, irq_n_ff}, 16'h0001);
    an_complete <= 1'b1;
    wt(6);
    chk({15'h0, irq_n_ff}, 16'h0000);
    rd(`ADDR_SRC_FLAGS);
    chk(rv, 16'h0444);
    chk({15'h0, irq_n_ff}, 16'h0001);
    pd_fault <= 1'b0;
    tx_overflow <= 1'b0;
  endtask
  task automatic t_isolate;
    wr(`ADDR_BASIC_CTRL, 16'h0400);
    chk({11'h0, media_enable_ff, rxd_ff}, 16'h000f);
    wr(`ADDR_INT_MASK, 16'hffff);
    rd(`ADDR_INT_MASK);
    chk(rv, `FLAG_IMPL);
    wr(`ADDR_INT_MASK, 16'h0190);
    link_up <= 1'b0;
    wt(6);
    chk({15'h0, irq_n_ff}, 16'h0000);
    rd(`ADDR_BASIC_STAT);
    chk(rv, 16'h0020);
    chk({15'h0, irq_n_ff}, 16'h0001);
    wr(`ADDR_BASIC_CTRL, 16'h0000);
    chk({15'h0, media_enable_ff}, 16'h0001);
  endtask
  task automatic t_events;
    line_energy <= 1'b0;
    wt(110);
    chk({15'h0, irq_n_ff}, 16'h0001);
    line_energy <= 1'b1;
    wt(6);
    chk({15'h0, irq_n_ff}, 16'h0000);
    idle_err_ovf <= 1'b1;
    tx_underflow <= 1'b1;
    page_rx <= 1'b1;
    wr(`ADDR_BASIC_CTRL, 16'h0200);
    rd(`ADDR_SRC_FLAGS);
    chk(rv, 16'h0380);
    chk({15'h0, irq_n_ff}, 16'h0000);
    idle_err_ovf <= 1'b0;
    tx_underflow <= 1'b0;
    page_rx <= 1'b0;
  endtask
  task automatic t_restrap;
    delay_mode_strap <= 1'b0;
    rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    wt(10);
    chk({14'h0, tx_delay_en_ff, rx_delay_en_ff}, 16'h0000);
    chk({15'h0, irq_n_ff}, 16'h0001);
    chk({15'h0, media_enable_ff}, 16'h0001);
  endtask
  task final_report;
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #390000;
    err_total++;
    final_report;
  end
  initial begin
    wt(6);
    rst_n <= 1'b1;
    wt(10);
    t_reset;
    t_delay;
    t_irq;
    t_isolate;
    t_events;
    t_unmapped;
    t_restrap;
    final_report;
  end
endmodule
